// file: pkg/sbad_pkg.sv
// Package of constants and types for the shared bus address decoder
package sbad_pkg;
	// Transfer type encoding on the bus transfer-type pins
	localparam logic [1:0] TRAN_ADDR_ONLY = 2'h0;
	localparam logic [1:0] TRAN_NONSEQ    = 2'h2;
	localparam logic [1:0] TRAN_SEQ       = 2'h3;
	// Transfer size encoding
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	// Protection field: bit 1 is privileged access
	localparam int PROT_PRIV_BIT = 1;
	// Geometry defaults
	localparam int NUM_SLAVES_DEF = 4;
	localparam int ADDR_W_DEF     = 32;
	localparam int REGION_LSB_DEF = 28;
	localparam int BOUNDARY_LSB_DEF = 10;
	// Response vector {wait, error, last}
	localparam logic [2:0] RESP_WAIT    = 3'h4;
	localparam logic [2:0] RESP_DONE    = 3'h0;
	localparam logic [2:0] RESP_LAST    = 3'h1;
	localparam logic [2:0] RESP_ERROR   = 3'h2;
	localparam logic [2:0] RESP_RETRACT = 3'h5;
	localparam int RESP_WAIT_BIT  = 2;
	localparam int RESP_ERROR_BIT = 1;
	localparam int RESP_LAST_BIT  = 0;

	typedef enum logic [1:0] {
		addr_only_state,
		decode_state,
		slave_selected_state,
		error_state
	} sbad_state_t;
endpackage

// file: pkg/sbad_dec_if.sv
// Interface between the decoder state machine and its address map
`timescale 1ns/1ps
interface sbad_dec_if #(
	parameter int NUM_SLAVES = 4,
	parameter int ADDR_W     = 32
);
	logic [ADDR_W-1:0]     addr;
	logic [1:0]            size;
	logic [1:0]            prot;
	logic                  write;
	logic [NUM_SLAVES-1:0] hit;
	logic                  boundary_last_flag;
	logic                  decode_error_flag;

	modport fsm (output addr, size, prot, write,
		input hit, boundary_last_flag, decode_error_flag);
	modport map (input addr, size, prot, write,
		output hit, boundary_last_flag, decode_error_flag);
endinterface

// file: rtl/sbad_map.sv
// Address map: slave hit, boundary and decode error detection
`timescale 1ns/1ps
module sbad_map
	import sbad_pkg::*;
#(
	parameter int NUM_SLAVES   = NUM_SLAVES_DEF,
	parameter int ADDR_W       = ADDR_W_DEF,
	parameter int REGION_LSB   = REGION_LSB_DEF,
	parameter int BOUNDARY_LSB = BOUNDARY_LSB_DEF,
	parameter logic [NUM_SLAVES-1:0] PRIV_ONLY = '0
) (
	sbad_dec_if.map m
);
	logic [ADDR_W-REGION_LSB-1:0] region;
	logic                         misaligned;
	logic                         protect_hit;

	// Region index selects a slave; indices past the last slave are unmapped
	always_comb begin
		region = m.addr[ADDR_W-1:REGION_LSB];
		m.hit  = '0;
		for (int i = 0; i < NUM_SLAVES; i++) begin
			if (region == (ADDR_W-REGION_LSB)'(i)) begin
				m.hit[i] = 1'b1;
			end
		end
		unique case (m.size)
			SIZE_BYTE: misaligned = 1'b0;
			SIZE_HALF: misaligned = m.addr[0];
			SIZE_WORD: misaligned = |m.addr[1:0];
			default:   misaligned = 1'b1;
		endcase
		protect_hit = |(m.hit & PRIV_ONLY) & ~m.prot[PROT_PRIV_BIT];
		m.decode_error_flag = ~(|m.hit) | protect_hit | misaligned;
		// Next sequential beat would enter a new boundary block
		m.boundary_last_flag = &m.addr[BOUNDARY_LSB-1:2];
	end
endmodule // sbad_map

// file: rtl/sbad_decoder.sv
// Shared bus address decoder with optional decode cycles
`timescale 1ns/1ps
// What this block does
// - One select output per slave, or none
// - Decode wait on non-sequential; sequential only after last, boundary or error
// - Error response for illegal or protected access
// - Decoder answers address-only transfers itself
// - Decode cycles also split bursts at boundaries
// - Four-state machine on falling clock edge
// - Reset enters address-only state
// - Transitions use type, response, internal flags
// - Not waited means done, last, error, retract
// - Boundary-last flag forces decode on sequential
// - Decode error: unmapped, protected or misaligned
// - Address-only: done, select if sequential valid
// - Decode state: wait, then select if valid
// - Slave selected: hold select while waited/sequential
// - Error state drives error response
// - Simpler variant when no decode wait needed
// - Simple variant omits decode state only
// - Response on wait, error, last; latched copies
module sbad_decoder
	import sbad_pkg::*;
#(
	parameter int NUM_SLAVES   = NUM_SLAVES_DEF,
	parameter int ADDR_W       = ADDR_W_DEF,
	parameter int REGION_LSB   = REGION_LSB_DEF,
	parameter int BOUNDARY_LSB = BOUNDARY_LSB_DEF,
	parameter bit USE_DECODE   = 1'b1,
	parameter logic [NUM_SLAVES-1:0] PRIV_ONLY = '0
) (
	input  wire logic                  ref_clk_i,
	input  wire logic                  rstn_i,
	input  wire logic [1:0]            tran_i,
	input  wire logic [ADDR_W-1:0]     addr_i,
	input  wire logic [1:0]            size_i,
	input  wire logic [1:0]            prot_i,
	input  wire logic                  write_i,
	input  wire logic                  wait_i,
	input  wire logic                  error_i,
	input  wire logic                  last_i,
	output logic [NUM_SLAVES-1:0]      sel_o,
	output logic                       wait_o,
	output logic                       error_o,
	output logic                       last_o,
	output logic                       resp_oe_o,
	output logic [1:0]                 state_o
);
	sbad_dec_if #(.NUM_SLAVES(NUM_SLAVES), .ADDR_W(ADDR_W)) dif ();

	sbad_map #(
		.NUM_SLAVES  (NUM_SLAVES),
		.ADDR_W      (ADDR_W),
		.REGION_LSB  (REGION_LSB),
		.BOUNDARY_LSB(BOUNDARY_LSB),
		.PRIV_ONLY   (PRIV_ONLY)
	) u_map (
		.m(dif)
	);

	assign dif.addr  = addr_i;
	assign dif.size  = size_i;
	assign dif.prot  = prot_i;
	assign dif.write = write_i;

	// Bus clock is modelled by ref_clk_i; the falling edge advances the state
	sbad_state_t           state;
	sbad_state_t           next_state;
	logic [2:0]            resp_lat;
	logic [2:0]            next_resp_lat;
	logic [2:0]            resp_drv;
	logic [2:0]            next_resp_drv;
	logic                  resp_oe;
	logic                  next_resp_oe;
	logic [NUM_SLAVES-1:0] sel;
	logic [NUM_SLAVES-1:0] next_sel;
	logic [NUM_SLAVES-1:0] sel_lat;
	logic [NUM_SLAVES-1:0] next_sel_lat;
	logic [1:0]            state_q;
	logic                  waited;
	logic                  is_seq;
	logic                  new_decode;

	function automatic logic not_waited(input logic [2:0] r);
		// Done, last, error and retract all end the beat
		return ~r[RESP_WAIT_BIT] | (r == RESP_RETRACT);
	endfunction

	// Latch slave response on the rising edge for falling-edge use
	always_comb begin
		next_resp_lat = {wait_i, error_i, last_i};
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			resp_lat <= RESP_DONE;
		end else begin
			resp_lat <= next_resp_lat;
		end
	end

	// Falling-edge state machine
	always_comb begin
		waited     = ~not_waited(resp_lat);
		is_seq     = (tran_i == TRAN_SEQ);
		// Last from slave or boundary forces re-decode
		new_decode = resp_lat[RESP_LAST_BIT] | dif.boundary_last_flag;
		next_state = state;
		unique case (state)
			addr_only_state: begin
				if (tran_i == TRAN_NONSEQ) begin
					next_state = USE_DECODE ? decode_state :
						(dif.decode_error_flag ? error_state : slave_selected_state);
				end else if (is_seq) begin
					next_state = dif.decode_error_flag ? error_state : slave_selected_state;
				end
			end
			decode_state: begin
				next_state = dif.decode_error_flag ? error_state : slave_selected_state;
			end
			slave_selected_state: begin
				if (waited) begin
					next_state = slave_selected_state;
				end else if (is_seq && !new_decode) begin
					next_state = slave_selected_state;
				end else if (tran_i == TRAN_ADDR_ONLY) begin
					next_state = addr_only_state;
				end else if (USE_DECODE) begin
					next_state = decode_state;
				end else begin
					next_state = dif.decode_error_flag ? error_state : slave_selected_state;
				end
			end
			error_state: begin
				if (tran_i == TRAN_ADDR_ONLY) begin
					next_state = addr_only_state;
				end else if (USE_DECODE) begin
					next_state = decode_state;
				end else begin
					next_state = dif.decode_error_flag ? error_state : slave_selected_state;
				end
			end
		endcase
		// Response chosen at the falling edge, driven by decoder from the next rising edge
		next_resp_oe  = 1'b1;
		next_resp_drv = RESP_DONE;
		unique case (next_state)
			addr_only_state:      next_resp_drv = RESP_DONE;
			decode_state:         next_resp_drv = RESP_WAIT;
			error_state:          next_resp_drv = RESP_ERROR;
			slave_selected_state: next_resp_oe  = 1'b0;
		endcase
	end

	always_ff @(negedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state    <= addr_only_state;
			resp_drv <= RESP_DONE;
			resp_oe  <= 1'b1;
		end else begin
			state    <= next_state;
			resp_drv <= next_resp_drv;
			resp_oe  <= next_resp_oe;
		end
	end

	// Select chosen at falling edge, presented from the rising edge (high phase)
	always_comb begin
		next_sel_lat = '0;
		unique case (state)
			addr_only_state: begin
				if (is_seq && !dif.decode_error_flag) begin
					next_sel_lat = dif.hit;
				end
			end
			decode_state: begin
				if (!dif.decode_error_flag) begin
					next_sel_lat = dif.hit;
				end
			end
			slave_selected_state: begin
				if (waited || (is_seq && !new_decode)) begin
					next_sel_lat = sel;
				end else if (!USE_DECODE && tran_i != TRAN_ADDR_ONLY
					&& !dif.decode_error_flag) begin
					next_sel_lat = dif.hit;
				end
			end
			error_state: begin
				if (!USE_DECODE && tran_i != TRAN_ADDR_ONLY && !dif.decode_error_flag) begin
					next_sel_lat = dif.hit;
				end
			end
		endcase
		if (!USE_DECODE && state == addr_only_state && tran_i == TRAN_NONSEQ
			&& !dif.decode_error_flag) begin
			next_sel_lat = dif.hit;
		end
	end

	always_ff @(negedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sel_lat <= '0;
		end else begin
			sel_lat <= next_sel_lat;
		end
	end

	always_comb begin
		next_sel = sel_lat;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sel     <= '0;
			state_q <= 2'h0;
			wait_o  <= 1'b0;
			error_o <= 1'b0;
			last_o  <= 1'b0;
			resp_oe_o <= 1'b1;
		end else begin
			sel     <= next_sel;
			state_q <= state;
			wait_o  <= resp_drv[RESP_WAIT_BIT];
			error_o <= resp_drv[RESP_ERROR_BIT];
			last_o  <= resp_drv[RESP_LAST_BIT];
			resp_oe_o <= resp_oe;
		end
	end

	// Outputs come straight from flops; response flops re-time to rising edge
	always_comb begin
		sel_o   = sel;
		state_o = state_q;
	end
endmodule // sbad_decoder

// file: test/sbad_props.sv
// Assertion checker for the shared bus address decoder
`timescale 1ns/1ps
module sbad_props
	import sbad_pkg::*;
#(
	parameter int NUM_SLAVES = NUM_SLAVES_DEF,
	parameter bit USE_DECODE = 1'b1
) (
	input wire logic                  ref_clk_i,
	input wire logic                  rstn_i,
	input wire logic [1:0]            tran_i,
	input wire logic                  wait_i,
	input wire logic                  last_i,
	input wire logic [NUM_SLAVES-1:0] sel_o,
	input wire logic                  wait_o,
	input wire logic                  error_o,
	input wire logic                  last_o,
	input wire logic                  resp_oe_o,
	input wire logic [1:0]            state_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	property p_onehot; $onehot0(sel_o); endproperty
	a_onehot: assert property (p_onehot) else $error("several selects");
	property p_aonly; state_o == 2'h0 |-> resp_oe_o && {wait_o, error_o, last_o} == RESP_DONE;
	endproperty
	a_aonly: assert property (p_aonly) else $error("idle response");
	property p_dec; state_o == 2'h1 |-> resp_oe_o && {wait_o, error_o, last_o} == RESP_WAIT;
	endproperty
	a_dec: assert property (p_dec) else $error("decode response");
	property p_err;
		state_o == 2'h3 |-> resp_oe_o && sel_o == '0 && {wait_o, error_o, last_o} == RESP_ERROR;
	endproperty
	a_err: assert property (p_err) else $error("error response");
	property p_ssel; state_o == 2'h2 |-> !resp_oe_o && $onehot(sel_o); endproperty
	a_ssel: assert property (p_ssel) else $error("slave phase");
	// Simple variant skips the decode cycle and goes straight to a slave or error
	property p_nseq;
		state_o == 2'h0 && tran_i == TRAN_NONSEQ |=> (USE_DECODE ? state_o == 2'h1 : state_o[1]);
	endproperty
	a_nseq: assert property (p_nseq) else $error("no decode cycle");
	property p_nodec; !USE_DECODE |-> state_o != 2'h1; endproperty
	a_nodec: assert property (p_nodec) else $error("decode in simple variant");
	property p_seq; state_o == 2'h0 && tran_i == TRAN_SEQ |=> state_o != 2'h1; endproperty
	a_seq: assert property (p_seq) else $error("needless decode");
	property p_dexit; state_o == 2'h1 |=> state_o[1]; endproperty
	a_dexit: assert property (p_dexit) else $error("decode exit");
	// Retract carries the wait bit too, but it ends the beat
	property p_hold;
		state_o == 2'h2 && $past(wait_i) && !$past(last_i) |=> state_o == 2'h2 && $stable(sel_o);
	endproperty
	a_hold: assert property (p_hold) else $error("waited drop");
	property p_last; state_o == 2'h2 && $past(last_i) && !$past(wait_i) |=> state_o != 2'h2;
	endproperty
	a_last: assert property (p_last) else $error("last ignored");
endmodule // sbad_props

// file: test/sbad_slave_model.sv
// Behavioural slave answering on the shared response lines
`timescale 1ns/1ps
module sbad_slave_model
	import sbad_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       sel_i,
	input  wire logic [1:0] waits_i,
	input  wire logic       last_i,
	output logic [2:0]      resp_o
);
	logic [1:0] cnt = 2'h0;
	initial resp_o = RESP_RETRACT;
	// Unselected it scrambles, so a stale value never passes
	always @(negedge ref_clk_i) begin
		if (!sel_i) begin
			resp_o <= ~resp_o;
			cnt <= 2'h0;
		end else if (cnt < waits_i) begin
			resp_o <= RESP_WAIT;
			cnt <= cnt + 2'h1;
		end else begin
			resp_o <= last_i ? RESP_LAST : RESP_DONE;
			cnt <= 2'h0;
		end
	end
endmodule // sbad_slave_model

// file: test/shared_bus_address_decoder_tb.sv
// Testbench for the shared bus address decoder
`timescale 1ns/1ps
module shared_bus_address_decoder_tb;
	import sbad_pkg::*;
	logic        ref_clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [1:0]  tran_i = TRAN_ADDR_ONLY;
	logic [31:0] addr_i = 32'h0;
	logic [1:0]  size_i = SIZE_WORD;
	logic [1:0]  prot_i = 2'h0;
	logic [1:0]  waits = 2'h0;
	logic        write_i = 1'b0;
	logic        last_req = 1'b0;
	logic [3:0]  sel_o;
	logic [2:0]  own, slv, bus;
	logic        resp_oe_o;
	logic [1:0]  state_o;
	logic [3:0]  sel_s;
	logic [2:0]  own_s;
	logic        resp_oe_s;
	logic [1:0]  state_s;
	logic [40:0] r;
	int          bad_count = 0;
	int          checked = 0;
	int          n;
	// Row: address, size, prot, select, error
	localparam logic [40:0] ROWS [8] = '{
		{32'h0000_0010, SIZE_WORD, 2'h0, 4'h1, 1'b0}, {32'h1000_0002, SIZE_HALF, 2'h0, 4'h2, 1'b0},
		{32'h2000_0003, SIZE_BYTE, 2'h0, 4'h4, 1'b0}, {32'h3000_0000, SIZE_WORD, 2'h2, 4'h8, 1'b0},
		{32'h4000_0000, SIZE_WORD, 2'h0, 4'h0, 1'b1}, {32'h3000_0000, SIZE_WORD, 2'h0, 4'h0, 1'b1},
		{32'h0000_0002, SIZE_WORD, 2'h0, 4'h0, 1'b1}, {32'h1000_0001, SIZE_HALF, 2'h0, 4'h0, 1'b1}};
	// Shared response wire: decoder or slave, by the decoder's enable
	assign bus = resp_oe_o ? own : slv;
	sbad_decoder #(.PRIV_ONLY(4'h8)) dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.tran_i(tran_i), .addr_i(addr_i), .size_i(size_i), .prot_i(prot_i), .write_i(write_i),
		.wait_i(bus[2]), .error_i(bus[1]), .last_i(bus[0]), .sel_o(sel_o), .wait_o(own[2]),
		.error_o(own[1]), .last_o(own[0]), .resp_oe_o(resp_oe_o), .state_o(state_o));
	// Simple variant: no decode cycle, its slave always answers done
	sbad_decoder #(.PRIV_ONLY(4'h8), .USE_DECODE(1'b0)) dut_simple (.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i), .tran_i(tran_i), .addr_i(addr_i), .size_i(size_i), .prot_i(prot_i),
		.write_i(write_i), .wait_i(resp_oe_s & own_s[2]), .error_i(resp_oe_s & own_s[1]),
		.last_i(resp_oe_s & own_s[0]), .sel_o(sel_s), .wait_o(own_s[2]), .error_o(own_s[1]),
		.last_o(own_s[0]), .resp_oe_o(resp_oe_s), .state_o(state_s));
	sbad_slave_model slave_u (.ref_clk_i(ref_clk_i), .sel_i(|sel_o), .waits_i(waits),
		.last_i(last_req), .resp_o(slv));
	initial forever #4 ref_clk_i = ~ref_clk_i;
	task automatic results();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [3:0] e, input logic [3:0] g);
		checked++;
		if (e !== g) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic drive(input logic [1:0] t, input logic [31:0] a);
		@(posedge ref_clk_i);
		tran_i <= t;
		addr_i <= a;
		#1;
	endtask
	task automatic wait_state(input logic [1:0] s);
		for (n = 0; state_o !== s && n < 20; n++) begin
			@(posedge ref_clk_i);
			#1;
		end
		chk("state_o", 4'(s), 4'(state_o));
		if (n == 20) results();
	endtask
	initial begin
		repeat (2) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			r = ROWS[i];
			size_i <= r[8:7];
			prot_i <= r[6:5];
			write_i <= 1'(i);
			drive(TRAN_NONSEQ, r[40:9]);
			drive(TRAN_ADDR_ONLY, r[40:9]);
			chk("decode", 4'(RESP_WAIT), {1'b0, own});
			chk("simple state", 4'(r[0] ? 2'h3 : 2'h2), 4'(state_s));
			chk("simple sel", r[4:1], sel_s);
			wait_state(r[0] ? 2'h3 : 2'h2);
			chk("sel_o", r[4:1], sel_o);
			chk("resp", r[0] ? {1'b1, RESP_ERROR} : 4'h0, {resp_oe_o, own & {3{resp_oe_o}}});
			wait_state(2'h0);
		end
		size_i <= SIZE_WORD;
		prot_i <= 2'h0;
		waits <= 2'h2;
		drive(TRAN_SEQ, 32'h3f8);
		drive(TRAN_SEQ, 32'h3f8);
		repeat (6) begin
			chk("seq", 4'h2, 4'(state_o));
			@(posedge ref_clk_i);
			#1;
		end
		drive(TRAN_SEQ, 32'h3fc);
		wait_state(2'h1);
		drive(TRAN_SEQ, 32'h3f0);
		wait_state(2'h2);
		last_req <= 1'b1;
		wait_state(2'h1);
		last_req <= 1'b0;
		wait_state(2'h2);
		rstn_i <= 1'b0;
		#1;
		chk("reset", {2'h0, 1'b0, 1'b1}, {state_o, |sel_o, resp_oe_o});
		chk("reset resp", 4'(RESP_DONE), {1'b0, own});
		drive(TRAN_ADDR_ONLY, 32'h0);
		@(posedge ref_clk_i);
		rstn_i <= 1'b1;
		wait_state(2'h0);
		drive(TRAN_NONSEQ, 32'h1000_0000);
		drive(TRAN_ADDR_ONLY, 32'h1000_0000);
		chk("decode after reset", 4'(RESP_WAIT), {1'b0, own});
		wait_state(2'h2);
		chk("sel_o after reset", 4'h2, sel_o);
		results();
	end
endmodule // shared_bus_address_decoder_tb
bind sbad_decoder sbad_props #(.NUM_SLAVES(NUM_SLAVES), .USE_DECODE(USE_DECODE)) props_u (
	.ref_clk_i(ref_clk_i),
	.rstn_i(rstn_i), .tran_i(tran_i), .wait_i(wait_i), .last_i(last_i), .sel_o(sel_o),
	.wait_o(wait_o), .error_o(error_o), .last_o(last_o), .resp_oe_o(resp_oe_o), .state_o(state_o));
